// [pkg/i2c_mm_pkg.sv]
// package for the multi-master i2c arbitration engine
//==============================================================
// Functional notes
// - reset disables port, ends transfer
// - stop and start seen cleared on reset/disable
// - stop seen while idle sets port irq
// - compare sda with intended output, flag loss
// - released one read zero: collide, go idle
// - byte collision: halt, clear full, release lines
// - sequence collision: abort, release, clear enable
// - new byte after collision starts at bit one
// - line low at start begin: collide, idle
// - start count runs, scl low collides
// - sda low in first count: drive early
// - second start count ignores scl, then scl low
// - restart: count, release scl, sda low collides
// - restart reload, scl early fall collides
// - restart both high: sda low, count, scl low
// - stop: release scl, count, sda low collides
// - stop: scl low before sda release collides
// - stop end sets stop seen, then irq
//==============================================================
package i2c_mm_pkg;
    // register offsets
    localparam logic [3:0] ADDR_STATUS   = 4'h0;
    localparam logic [3:0] ADDR_CTRL_ONE = 4'h1;
    localparam logic [3:0] ADDR_CTRL_TWO = 4'h2;
    localparam logic [3:0] ADDR_RELOAD   = 4'h3;
    localparam logic [3:0] ADDR_BUFFER   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_FLAG = 4'h5;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h6;
    // field positions
    localparam int STAT_FULL   = 0;
    localparam int STAT_START  = 3;
    localparam int STAT_STOP   = 4;
    localparam int C1_ENABLE   = 5;
    localparam int C2_START    = 0;
    localparam int C2_RESTART  = 1;
    localparam int C2_STOP     = 2;
    localparam int C2_ACK      = 4;
    localparam int C2_ACKDT    = 5;
    localparam int C2_ACKSTAT  = 6;
    localparam int IRQ_PORT    = 0;
    localparam int IRQ_COLL    = 1;
    // reset values
    localparam logic [7:0] RELOAD_RST = 8'h09;
    localparam logic [7:0] ZERO8      = 8'h00;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
        logic scl_o;
        logic scl_oe;
    } pin_drv_s;
endpackage

// [src/i2c_line_sync.sv]
// two-flop synchroniser and edge finder for the i2c lines
module i2c_line_sync (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // raw line
    input  wire logic line_i,
    // synchronised level and edges
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    // lines idle high through the pull-ups, so reset to one
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= line_i;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end
    assign level_o = sync_ff;
    assign rise_o  = sync_ff & ~prev_ff;
    assign fall_o  = ~sync_ff & prev_ff;
endmodule // i2c_line_sync

// [src/i2c_mm_master.sv]
// multi-master i2c engine: sequences, arbitration, register file
module i2c_mm_master (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // register port
    input  wire i2c_mm_pkg::bus_req_s req_i,
    output logic [7:0]             rdata_o,
    // bus lines, open drain (oe high pulls low)
    input  wire logic              sda_i,
    input  wire logic              scl_i,
    output i2c_mm_pkg::pin_drv_s   pin_o,
    // interrupt requests
    output logic                   port_irq_o,
    output logic                   coll_irq_o
);
    import i2c_mm_pkg::*;

    typedef enum {
        S_IDLE, S_ST_WAIT, S_ST_HOLD,
        S_RS_SDA, S_RS_SCL, S_RS_HI, S_RS_HOLD,
        S_SP_SDA, S_SP_SCL, S_SP_HI, S_SP_REL, S_SP_DONE,
        S_TX_LO, S_TX_HI, S_AK_LO, S_AK_HI
    } state_e;

    //==========================================================
    // line sampling
    //==========================================================
    logic sda_s, sda_rise, sda_fall;
    logic scl_s;
    i2c_line_sync u_sda (.clk_i(clk_i), .arst_n_i(arst_n_i), .line_i(sda_i),
                         .level_o(sda_s), .rise_o(sda_rise), .fall_o(sda_fall));
    i2c_line_sync u_scl (.clk_i(clk_i), .arst_n_i(arst_n_i), .line_i(scl_i),
                         .level_o(scl_s), .rise_o(), .fall_o());

    //==========================================================
    // state
    //==========================================================
    state_e     state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [3:0] bit_ff, nxt_bit;
    logic       sda_drv_ff, nxt_sda_drv;
    logic       scl_drv_ff, nxt_scl_drv;
    logic [7:0] reload_ff, ctrl1_ff, ctrl2_ff, irq_en_ff;
    logic       full_ff, start_seen_ff, stop_seen_ff, ackstat_ff;
    logic       port_flag_ff, coll_flag_ff;
    logic [7:0] rdata_ff;
    logic       port_irq_ff, coll_irq_ff;

    //==========================================================
    // decode
    //==========================================================
    wire enabled   = ctrl1_ff[C1_ENABLE];
    wire wr_ctrl1  = req_i.wr && req_i.addr == ADDR_CTRL_ONE;
    wire wr_ctrl2  = req_i.wr && req_i.addr == ADDR_CTRL_TWO;
    wire wr_reload = req_i.wr && req_i.addr == ADDR_RELOAD;
    wire wr_buf    = req_i.wr && req_i.addr == ADDR_BUFFER;
    wire wr_flag   = req_i.wr && req_i.addr == ADDR_IRQ_FLAG;
    wire wr_en     = req_i.wr && req_i.addr == ADDR_IRQ_EN;
    wire cnt_done  = cnt_ff == ZERO8;
    wire idle      = state_ff == S_IDLE;
    wire want_sda  = ~sda_drv_ff;
    // bus-level start and stop seen by any master
    wire bus_start = sda_fall & scl_s;
    wire bus_stop  = sda_rise & scl_s;
    // arbitration: released line read low while scl high
    // the ninth clock is the slave's ack slot, not arbitration
    wire tx_lost   = (state_ff == S_TX_HI || state_ff == S_AK_HI)
                     && !(state_ff == S_TX_HI && bit_ff == 4'h8)
                     && want_sda && !sda_s && scl_s;
    logic coll_evt, port_evt, clr_seq;

    //==========================================================
    // sequencer
    //==========================================================
    always_comb begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_done ? ZERO8 : cnt_ff - 8'h01;
        nxt_shift   = shift_ff;
        nxt_bit     = bit_ff;
        nxt_sda_drv = sda_drv_ff;
        nxt_scl_drv = scl_drv_ff;
        coll_evt    = 1'b0;
        port_evt    = 1'b0;
        clr_seq     = 1'b0;
        unique case (state_ff)
            S_IDLE: begin
                nxt_cnt = reload_ff;
                if (wr_ctrl2 && req_i.wdata[C2_START] && enabled) begin
                    if (!sda_s || !scl_s) begin
                        coll_evt = 1'b1;
                        clr_seq  = 1'b1;
                    end else begin
                        nxt_state = S_ST_WAIT;
                    end
                end else if (wr_ctrl2 && req_i.wdata[C2_RESTART] && enabled) begin
                    nxt_sda_drv = 1'b0;
                    nxt_state   = S_RS_SDA;
                end else if (wr_ctrl2 && req_i.wdata[C2_STOP] && enabled) begin
                    nxt_sda_drv = 1'b1;
                    nxt_state   = S_SP_SDA;
                end else if (wr_ctrl2 && req_i.wdata[C2_ACK] && enabled) begin
                    nxt_scl_drv = 1'b1;
                    nxt_sda_drv = ~req_i.wdata[C2_ACKDT];
                    nxt_state   = S_AK_LO;
                end else if (wr_buf && enabled) begin
                    nxt_shift   = req_i.wdata;
                    nxt_bit     = 4'h0;
                    nxt_scl_drv = 1'b1;
                    nxt_sda_drv = ~req_i.wdata[7];
                    nxt_state   = S_TX_LO;
                end
            end
            S_ST_WAIT: begin
                if (sda_s && !scl_s) begin
                    coll_evt = 1'b1;
                end else if (!sda_s || cnt_done) begin
                    nxt_sda_drv = 1'b1;
                    nxt_cnt     = reload_ff;
                    nxt_state   = S_ST_HOLD;
                end
            end
            S_ST_HOLD: if (cnt_done) begin
                nxt_scl_drv = 1'b1;
                port_evt    = 1'b1;
                clr_seq     = 1'b1;
                nxt_state   = S_IDLE;
            end
            S_RS_SDA: begin
                if (!sda_s) nxt_cnt = reload_ff;
                else if (cnt_done) begin
                    nxt_scl_drv = 1'b0;
                    nxt_state   = S_RS_SCL;
                end
            end
            S_RS_SCL: begin
                nxt_cnt = reload_ff;
                if (scl_s) begin
                    if (!sda_s) coll_evt = 1'b1;
                    else nxt_state = S_RS_HI;
                end
            end
            S_RS_HI: begin
                if (!scl_s && sda_s) coll_evt = 1'b1;
                // sda falling first is a rival restart
                else if (!sda_s) begin
                    nxt_sda_drv = 1'b1;
                    nxt_cnt     = reload_ff;
                    nxt_state   = S_RS_HOLD;
                end else if (cnt_done) begin
                    nxt_sda_drv = 1'b1;
                    nxt_cnt     = reload_ff;
                    nxt_state   = S_RS_HOLD;
                end
            end
            S_RS_HOLD: if (cnt_done) begin
                nxt_scl_drv = 1'b1;
                port_evt    = 1'b1;
                clr_seq     = 1'b1;
                nxt_state   = S_IDLE;
            end
            S_SP_SDA: begin
                nxt_cnt = reload_ff;
                if (!sda_s) begin
                    nxt_scl_drv = 1'b0;
                    nxt_state   = S_SP_SCL;
                end
            end
            S_SP_SCL: begin
                nxt_cnt = reload_ff;
                if (scl_s) nxt_state = S_SP_HI;
            end
            S_SP_HI: begin
                if (!scl_s) coll_evt = 1'b1;
                else if (cnt_done) begin
                    nxt_sda_drv = 1'b0;
                    nxt_cnt     = reload_ff;
                    nxt_state   = S_SP_REL;
                end
            end
            S_SP_REL: begin
                // rival still holding sda low owns the bus
                if (cnt_done && !sda_s) coll_evt = 1'b1;
                else if (sda_s && scl_s && cnt_done) begin
                    nxt_cnt   = reload_ff;
                    nxt_state = S_SP_DONE;
                end
            end
            S_SP_DONE: if (cnt_done) begin
                port_evt  = 1'b1;
                clr_seq   = 1'b1;
                nxt_state = S_IDLE;
            end
            S_TX_LO, S_AK_LO: if (cnt_done) begin
                nxt_scl_drv = 1'b0;
                nxt_cnt     = reload_ff;
                nxt_state   = (state_ff == S_TX_LO) ? S_TX_HI : S_AK_HI;
            end
            S_TX_HI, S_AK_HI: begin
                // clock stretching: count only once scl reads high
                if (!scl_s) nxt_cnt = reload_ff;
                if (tx_lost) coll_evt = 1'b1;
                else if (cnt_done) begin
                    nxt_scl_drv = 1'b1;
                    nxt_cnt     = reload_ff;
                    // ninth clock closes the byte
                    if (state_ff == S_AK_HI || bit_ff == 4'h8) begin
                        port_evt  = 1'b1;
                        clr_seq   = 1'b1;
                        nxt_state = S_IDLE;
                    end else begin
                        nxt_bit     = bit_ff + 4'h1;
                        nxt_shift   = {shift_ff[6:0], 1'b0};
                        nxt_sda_drv = (bit_ff == 4'h7) ? 1'b0 : ~shift_ff[6];
                        nxt_state   = S_TX_LO;
                    end
                end
            end
        endcase
        // any collision releases both lines and parks the engine
        if (coll_evt) begin
            nxt_sda_drv = 1'b0;
            nxt_scl_drv = 1'b0;
            // next byte starts at its first bit
            nxt_bit     = 4'h0;
            clr_seq     = 1'b1;
            nxt_state   = S_IDLE;
        end
        if (!enabled) begin
            nxt_state   = S_IDLE;
            nxt_sda_drv = 1'b0;
            nxt_scl_drv = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff   <= S_IDLE;
            cnt_ff     <= ZERO8;
            shift_ff   <= ZERO8;
            bit_ff     <= 4'h0;
            sda_drv_ff <= 1'b0;
            scl_drv_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            shift_ff   <= nxt_shift;
            bit_ff     <= nxt_bit;
            sda_drv_ff <= nxt_sda_drv;
            scl_drv_ff <= nxt_scl_drv;
        end
    end

    //==========================================================
    // registers and flags
    //==========================================================
    wire ack_capture = state_ff == S_TX_HI && bit_ff == 4'h8 && cnt_done && scl_s;
    // a tx collision drops the full flag so the buffer is writable again
    wire full_clr    = coll_evt || (ack_capture && !tx_lost);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reload_ff     <= RELOAD_RST;
            ctrl1_ff      <= ZERO8;
            ctrl2_ff      <= ZERO8;
            irq_en_ff     <= ZERO8;
            full_ff       <= 1'b0;
            start_seen_ff <= 1'b0;
            stop_seen_ff  <= 1'b0;
            ackstat_ff    <= 1'b0;
            port_flag_ff  <= 1'b0;
            coll_flag_ff  <= 1'b0;
        end else begin
            if (wr_reload) reload_ff <= req_i.wdata;
            if (wr_ctrl1) ctrl1_ff <= req_i.wdata;
            if (wr_en) irq_en_ff <= req_i.wdata;
            if (clr_seq) ctrl2_ff[4:0] <= 5'h00;
            else if (wr_ctrl2 && idle) ctrl2_ff <= req_i.wdata;
            if (full_clr) full_ff <= 1'b0;
            else if (wr_buf && idle && enabled) full_ff <= 1'b1;
            if (ack_capture) ackstat_ff <= sda_s;
            if (!enabled) begin
                start_seen_ff <= 1'b0;
                stop_seen_ff  <= 1'b0;
            end else if (bus_start) begin
                start_seen_ff <= 1'b1;
                stop_seen_ff  <= 1'b0;
            end else if (bus_stop) begin
                start_seen_ff <= 1'b0;
                stop_seen_ff  <= 1'b1;
            end
            // set wins over a software clear in the same cycle
            // own stops flag at their end, rival stops only while idle
            if (port_evt || (bus_stop && enabled && idle && start_seen_ff)) begin
                port_flag_ff <= 1'b1;
            end else if (wr_flag && !req_i.wdata[IRQ_PORT]) begin
                port_flag_ff <= 1'b0;
            end
            if (coll_evt) coll_flag_ff <= 1'b1;
            else if (wr_flag && !req_i.wdata[IRQ_COLL]) coll_flag_ff <= 1'b0;
        end
    end

    //==========================================================
    // read data and outputs
    //==========================================================
    // unmapped offsets read as zero
    logic [7:0] rd_mux;
    assign rd_mux =
        (req_i.addr == ADDR_STATUS)   ? {3'h0, stop_seen_ff, start_seen_ff, 2'h0, full_ff} :
        (req_i.addr == ADDR_CTRL_ONE) ? ctrl1_ff :
        (req_i.addr == ADDR_CTRL_TWO) ? {1'b0, ackstat_ff, ctrl2_ff[5:0]} :
        (req_i.addr == ADDR_RELOAD)   ? reload_ff :
        (req_i.addr == ADDR_BUFFER)   ? shift_ff :
        (req_i.addr == ADDR_IRQ_FLAG) ? {6'h00, coll_flag_ff, port_flag_ff} :
        (req_i.addr == ADDR_IRQ_EN)   ? irq_en_ff : ZERO8;
    // irq levels: flag and enable
    wire nxt_port_irq = port_flag_ff & irq_en_ff[IRQ_PORT];
    wire nxt_coll_irq = coll_flag_ff & irq_en_ff[IRQ_COLL];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_ff    <= ZERO8;
            port_irq_ff <= 1'b0;
            coll_irq_ff <= 1'b0;
        end else begin
            rdata_ff    <= req_i.rd ? rd_mux : ZERO8;
            port_irq_ff <= nxt_port_irq;
            coll_irq_ff <= nxt_coll_irq;
        end
    end

    assign rdata_o      = rdata_ff;
    assign port_irq_o   = port_irq_ff;
    assign coll_irq_o   = coll_irq_ff;
    assign pin_o.sda_o  = 1'b0;
    assign pin_o.scl_o  = 1'b0;
    assign pin_o.sda_oe = sda_drv_ff;
    assign pin_o.scl_oe = scl_drv_ff;
endmodule // i2c_mm_master

// [tb/i2c_bus_peer.sv]
// bus peer: a slave that acknowledges and a second master that grabs the lines
module i2c_bus_peer (
    // link clock of the peer, unrelated to the engine clock
    input  wire logic lclk_i,
    // line levels
    input  wire logic sda_i,
    input  wire logic scl_i,
    // commands from the bench
    input  wire logic ack_en_i,
    input  wire logic grab_sda_i,
    input  wire logic grab_scl_i,
    // pulls, high pulls the line low
    output logic      sda_pull_o,
    output logic      scl_pull_o
);
    timeunit 1ns;
    timeprecision 1ps;
    //==========================================================
    // falls of scl since the last start: the start itself gives one
    logic [3:0] nfall_ff    = 4'h0;
    logic       grab_sda_ff = 1'b0;
    logic       grab_scl_ff = 1'b0;
    always @(negedge sda_i) if (scl_i) nfall_ff <= 4'h0;
    always @(negedge scl_i) nfall_ff <= (nfall_ff == 4'h9) ? 4'h1 : nfall_ff + 4'h1;
    // grabs change only on the peer's own clock
    always @(posedge lclk_i) begin
        grab_sda_ff <= grab_sda_i;
        grab_scl_ff <= grab_scl_i;
    end
    // ack is held from the ninth fall to the tenth
    assign sda_pull_o = grab_sda_ff || (ack_en_i && (nfall_ff == 4'h9));
    assign scl_pull_o = grab_scl_ff;
endmodule // i2c_bus_peer

// [tb/i2c_mm_props.sv]
// assertion checker for the multi-master i2c engine, bound to its top module
module i2c_mm_props (
    // clock and reset
    input wire logic                 clk_i,
    input wire logic                 arst_n_i,
    // register port
    input wire i2c_mm_pkg::bus_req_s req_i,
    input wire logic [7:0]           rdata_o,
    // bus lines
    input wire logic                 sda_i,
    input wire logic                 scl_i,
    input wire i2c_mm_pkg::pin_drv_s pin_o,
    // interrupt requests
    input wire logic                 port_irq_o,
    input wire logic                 coll_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_mm_pkg::*;
    //==========================================================
    // shadows of register writes and of the raw lines
    logic en_ff, en_q_ff, pen_ff, seen_ff, sda_q_ff, scl_q_ff;
    wire  wr_ie    = req_i.wr && (req_i.addr == ADDR_IRQ_EN);
    wire  wr_if    = req_i.wr && (req_i.addr == ADDR_IRQ_FLAG);
    wire  wr_c1    = req_i.wr && (req_i.addr == ADDR_CTRL_ONE);
    wire  go_start = req_i.wr && (req_i.addr == ADDR_CTRL_TWO) && req_i.wdata[C2_START];
    wire  port_off = !en_ff && !en_q_ff;
    wire  start_ev = sda_q_ff && !sda_i && scl_q_ff && scl_i;
    wire  stop_ev  = !sda_q_ff && sda_i && scl_q_ff && scl_i;
    wire  nxt_seen = en_ff && (start_ev || (seen_ff && !stop_ev));
    // lines idle high, so the shadows reset high to avoid a false stop
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {en_ff, en_q_ff, pen_ff, seen_ff} <= 4'h0;
            {sda_q_ff, scl_q_ff}               <= 2'h3;
        end else begin
            en_ff    <= wr_c1 ? req_i.wdata[C1_ENABLE] : en_ff;
            en_q_ff  <= en_ff;
            pen_ff   <= wr_ie ? req_i.wdata[IRQ_PORT] : pen_ff;
            seen_ff  <= nxt_seen;
            sda_q_ff <= sda_i;
            scl_q_ff <= scl_i;
        end
    end
    //==========================================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_rst_quiet;
        $rose(arst_n_i) |-> !pin_o.sda_oe && !pin_o.scl_oe && !port_irq_o && !coll_irq_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
    property p_off_quiet;
        port_off |-> !pin_o.sda_oe && !pin_o.scl_oe;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("disabled port drives a line");
    property p_seen_clr;
        req_i.rd && (req_i.addr == ADDR_STATUS) && port_off
            |=> !rdata_o[STAT_START] && !rdata_o[STAT_STOP];
    endproperty
    a_seen_clr: assert property (p_seen_clr) else $error("seen flags set while disabled");
    property p_coll_rel;
        $rose(coll_irq_o) |-> ##[0:3] (!pin_o.sda_oe && !pin_o.scl_oe);
    endproperty
    a_coll_rel: assert property (p_coll_rel) else $error("lines held after collision");
    property p_coll_hold;
        coll_irq_o && !wr_ie && !wr_if && !$past(wr_ie) && !$past(wr_if) |=> coll_irq_o;
    endproperty
    a_coll_hold: assert property (p_coll_hold) else $error("collision irq dropped");
    property p_start_order;
        $rose(pin_o.sda_oe) && !pin_o.scl_oe |-> ##[1:40] pin_o.scl_oe;
    endproperty
    a_start_order: assert property (p_start_order) else $error("scl not driven after sda");
    property p_start_abort;
        go_start && !scl_i && !$past(scl_i, 3) && !pin_o.sda_oe && !pin_o.scl_oe
            |=> !pin_o.sda_oe [*8];
    endproperty
    a_start_abort: assert property (p_start_abort) else $error("start went on with scl low");
    property p_stop_irq;
        stop_ev && seen_ff && pen_ff && en_ff |-> ##[1:40] port_irq_o;
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("no port irq after stop");
    c_start: cover property (start_ev);
    c_coll: cover property ($rose(coll_irq_o));
    c_stop: cover property (stop_ev && seen_ff);
endmodule // i2c_mm_props

bind i2c_mm_master i2c_mm_props u_i2c_mm_props (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req_i), .rdata_o(rdata_o), .sda_i(sda_i),
    .scl_i(scl_i), .pin_o(pin_o), .port_irq_o(port_irq_o), .coll_irq_o(coll_irq_o)
);

// [tb/tb.sv]
// self-checking bench for the multi-master i2c engine
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_mm_pkg::*;
    //==========================================================
    // signals
    logic       clk_i    = 1'b0;
    logic       arst_n_i = 1'b0;
    logic       lclk     = 1'b0;
    bus_req_s   req      = '0;
    logic [7:0] rdata;
    pin_drv_s   pin;
    logic       port_irq, coll_irq, sda_pull, scl_pull;
    logic       ack_en   = 1'b0;
    logic       grab_sda = 1'b0;
    logic       grab_scl = 1'b0;
    logic [8:0] bits     = 9'h000;
    int         n_errors = 0;
    int         checked  = 0;
    int         cyc      = 0;
    // pull-ups: a released line reads high
    wire        sda_w    = !(pin.sda_oe || sda_pull);
    wire        scl_w    = !(pin.scl_oe || scl_pull);
    always #5 clk_i = !clk_i;
    initial begin
        #3;
        forever #40 lclk = !lclk;
    end
    always @(posedge scl_w) bits <= {bits[7:0], sda_w};
    i2c_mm_master u_i2c_mm_master (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req),
        .rdata_o(rdata), .sda_i(sda_w), .scl_i(scl_w), .pin_o(pin), .port_irq_o(port_irq),
        .coll_irq_o(coll_irq));
    i2c_bus_peer u_i2c_bus_peer (.lclk_i(lclk), .sda_i(sda_w), .scl_i(scl_w), .ack_en_i(ack_en),
        .grab_sda_i(grab_sda), .grab_scl_i(grab_scl), .sda_pull_o(sda_pull),
        .scl_pull_o(scl_pull));
    //==========================================================
    // tasks
    task automatic results();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_i);
        req.wr <= 1'b0;
        @(posedge clk_i);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, string w);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_i);
        req.rd <= 1'b0;
        @(negedge clk_i);
        chk(w, e, rdata & m);
        @(posedge clk_i);
    endtask
    task automatic wait_irq(input bit coll);
        int i;
        for (i = 0; i < 3000; i++) begin
            if ((coll ? coll_irq : port_irq) === 1'b1) break;
            @(posedge clk_i);
        end
        chk("irq", 8'h01, {7'h00, coll ? coll_irq : port_irq});
    endtask
    task automatic start();
        wr(ADDR_CTRL_TWO, 8'h01);
        wait_irq(1'b0);
        chk("lines", 8'h00, {6'h00, sda_w, scl_w});
        rd(ADDR_STATUS, 8'h08, 8'h08, "start_seen");
        wr(ADDR_IRQ_FLAG, 8'h00);
    endtask
    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_errors++;
            results();
        end
    end
    //==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(ADDR_STATUS, 8'hFF, ZERO8, "status");
        rd(ADDR_RELOAD, 8'hFF, RELOAD_RST, "reload");
        rd(4'hF, 8'hFF, ZERO8, "unmapped");
        wr(ADDR_CTRL_ONE, 8'h20);
        wr(ADDR_RELOAD, 8'h05);
        wr(ADDR_IRQ_EN, 8'h03);
        rd(ADDR_IRQ_EN, 8'hFF, 8'h03, "irq_en");
        start();
        // a second master holds sda low while a one is sent
        grab_sda <= 1'b1;
        wr(ADDR_BUFFER, 8'h0F);
        wait_irq(1'b1);
        chk("oe", 8'h00, {6'h00, pin.sda_oe, pin.scl_oe});
        rd(ADDR_STATUS, 8'h01, 8'h00, "full");
        repeat (20) @(posedge clk_i);
        chk("coll_hold", 8'h01, {7'h00, coll_irq});
        wr(ADDR_IRQ_FLAG, 8'h00);
        @(posedge clk_i);
        chk("coll_clr", 8'h00, {7'h00, coll_irq});
        grab_sda <= 1'b0;
        wait_irq(1'b0);
        rd(ADDR_STATUS, 8'h10, 8'h10, "stop_seen");
        wr(ADDR_IRQ_FLAG, 8'h00);
        start();
        ack_en <= 1'b1;
        wr(ADDR_BUFFER, 8'hA5);
        wait_irq(1'b0);
        chk("wire_byte", 8'hA5, bits[8:1]);
        rd(ADDR_CTRL_TWO, 8'h40, 8'h00, "ackstat");
        wr(ADDR_IRQ_FLAG, 8'h00);
        wr(ADDR_CTRL_TWO, 8'h30);
        wait_irq(1'b0);
        chk("ack_bit", 8'h01, {7'h00, bits[0]});
        rd(ADDR_CTRL_TWO, 8'h10, 8'h00, "ack_en");
        wr(ADDR_IRQ_FLAG, 8'h00);
        wr(ADDR_CTRL_TWO, 8'h02);
        wait_irq(1'b0);
        chk("restart", 8'h00, {6'h00, sda_w, scl_w});
        rd(ADDR_CTRL_TWO, 8'h02, 8'h00, "restart_en");
        wr(ADDR_IRQ_FLAG, 8'h00);
        wr(ADDR_CTRL_TWO, 8'h04);
        wait_irq(1'b0);
        rd(ADDR_STATUS, 8'h10, 8'h10, "stop_end");
        rd(ADDR_CTRL_TWO, 8'h04, 8'h00, "stop_en");
        chk("idle", 8'h03, {6'h00, sda_w, scl_w});
        wr(ADDR_IRQ_FLAG, 8'h00);
        ack_en <= 1'b0;
        // start attempted while another master holds scl low
        grab_scl <= 1'b1;
        repeat (20) @(posedge clk_i);
        wr(ADDR_CTRL_TWO, 8'h01);
        wait_irq(1'b1);
        rd(ADDR_CTRL_TWO, 8'h01, 8'h00, "start_en");
        grab_scl <= 1'b0;
        wr(ADDR_IRQ_FLAG, 8'h00);
        wr(ADDR_CTRL_ONE, 8'h00);
        rd(ADDR_STATUS, 8'h18, 8'h00, "seen_off");
        // reset in the middle of a byte
        wr(ADDR_CTRL_ONE, 8'h20);
        start();
        wr(ADDR_BUFFER, 8'h00);
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b0;
        @(negedge clk_i);
        chk("rst_oe", 8'h00, {6'h00, pin.sda_oe, pin.scl_oe});
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(ADDR_CTRL_ONE, 8'hFF, ZERO8, "rst_ctrl1");
        rd(ADDR_STATUS, 8'hFF, ZERO8, "rst_status");
        results();
    end
endmodule // tb
